// ---- rtl/rrso_core.sv ----
// Summary of operation
// - Return pops stack top into program counter.
// - Return takes two cycles, discards fetch, flags kept.
// - Rotate left through carry, only carry changes.
// - Rotate left destination: 0 working, 1 file.
// - Rotate right through carry, only carry changes.
// - Rotate right destination: 0 working, 1 file.
// - Sleep clears powerdown flag, sets timeout flag.
// - Sleep clears watchdog count and prescaler.
// - Sleep stops oscillator and execution until wake.
`include "rrso_map.svh"

module rrso_core
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic wakeEvent,
  output logic oscStop,
  output logic wdtClear,
  output logic prescClear,
  output logic discardFetch
);
  import rrso_pkg::*;

  rrso_state_t state_ff;
  logic [1:0] phase_ff;
  logic [13:0] instr_ff;
  rrso_dec_t dec;
  logic [7:0] wreg_ff;
  logic carry_ff;
  logic pdown_ff;
  logic tout_ff;
  logic [12:0] pc_ff;
  logic [12:0] stack_ff [8];
  logic [2:0] sp_ff;
  logic [12:0] stackTop;
  logic [6:0] fileAddr_ff;
  logic [7:0] memRdata;
  rrso_memreq_t memReq;
  logic wakeMeta_ff;
  logic wakeSync_ff;
  rrso_aphase_t aph_ff;
  logic [31:0] hrdata_ff;
  logic [1:0] fdWait_ff;
  logic [31:0] readMux;
  logic [31:0] statusWord;
  logic oscStop_ff;
  logic wdtClear_ff;
  logic prescClear_ff;
  logic commit;
  logic isRot;
  logic issue;
  logic swIdleWr;
  logic [8:0] rotResult;

  function automatic rrso_dec_t decodeOp(input logic [13:0] op);
    rrso_dec_t d;
    d.dest = op[7];
    d.fAddr = op[6:0];
    if (op == `RRSO_OP_RETURN)
      d.kind = RRSO_K_RET;
    else if (op == `RRSO_OP_SLEEP)
      d.kind = RRSO_K_SLEEP;
    else if (op[13:8] == `RRSO_OP_ROTL)
      d.kind = RRSO_K_ROTL;
    else if (op[13:8] == `RRSO_OP_ROTR)
      d.kind = RRSO_K_ROTR;
    else
      d.kind = RRSO_K_NONE;
    return d;
  endfunction : decodeOp

  // Carry out in bit 8, rotated byte below it.
  function automatic logic [8:0] rotateThroughCarry(input logic [7:0] v, input logic c, input logic left);
    if (left)
      return {v[7], v[6:0], c};
    return {v[0], c, v[7:1]};
  endfunction : rotateThroughCarry

  function automatic logic busWrite(input rrso_aphase_t a, input logic [11:0] off);
    return a.sel && a.wr && (a.addr == off);
  endfunction : busWrite

  assign dec = decodeOp(instr_ff);
  assign isRot = (dec.kind == RRSO_K_ROTL) || (dec.kind == RRSO_K_ROTR);
  assign commit = (state_ff == RRSO_EXEC) && (phase_ff == `RRSO_QLAST);
  assign issue = busWrite(aph_ff, `RRSO_OFF_INSTR) && (state_ff == RRSO_IDLE);
  assign swIdleWr = (state_ff == RRSO_IDLE);
  assign stackTop = stack_ff[sp_ff - 3'h1];
  assign rotResult = rotateThroughCarry(memRdata, carry_ff, dec.kind == RRSO_K_ROTL);

  // The wake pin is asynchronous, so it is synchronised before the sleep logic sees it.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      wakeMeta_ff <= 1'b0;
      wakeSync_ff <= 1'b0;
    end
    else
    begin
      wakeMeta_ff <= wakeEvent;
      wakeSync_ff <= wakeMeta_ff;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      state_ff <= RRSO_IDLE;
      phase_ff <= 2'h0;
      instr_ff <= 14'h0000;
    end
    else
    begin
      phase_ff <= phase_ff + 2'h1;
      case (state_ff)
        RRSO_IDLE:
        begin
          phase_ff <= 2'h0;
          if (issue)
          begin
            instr_ff <= hwdata[13:0];
            state_ff <= RRSO_EXEC;
          end
        end
        RRSO_EXEC:
        begin
          if (commit)
          begin
            if (dec.kind == RRSO_K_RET)
              state_ff <= RRSO_FLUSH;
            else if (dec.kind == RRSO_K_SLEEP)
              state_ff <= RRSO_SLEEP;
            else
              state_ff <= RRSO_IDLE;
          end
        end
        RRSO_FLUSH:
        begin
          if (phase_ff == `RRSO_QLAST)
            state_ff <= RRSO_IDLE;
        end
        RRSO_SLEEP:
        begin
          phase_ff <= 2'h0;
          if (wakeSync_ff)
            state_ff <= RRSO_IDLE;
        end
        default:
        begin
          state_ff <= RRSO_IDLE;
        end
      endcase
    end
  end

  // Flags: the instruction in flight wins over a software write in the same cycle.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      carry_ff <= `RRSO_CARRY_RST;
      pdown_ff <= `RRSO_PDOWN_RST;
      tout_ff <= `RRSO_TOUT_RST;
    end
    else if (commit && isRot)
    begin
      carry_ff <= rotResult[8];
    end
    else if (commit && (dec.kind == RRSO_K_SLEEP))
    begin
      pdown_ff <= 1'b0;
      tout_ff <= 1'b1;
    end
    else if (busWrite(aph_ff, `RRSO_OFF_STATUS))
    begin
      carry_ff <= hwdata[`RRSO_ST_CARRY];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      wreg_ff <= `RRSO_WREG_RST;
    else if (commit && isRot && !dec.dest)
      wreg_ff <= rotResult[7:0];
    else if (busWrite(aph_ff, `RRSO_OFF_WREG))
      wreg_ff <= hwdata[7:0];
  end

  // Program counter and return stack; software can only push or steer them while idle.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      pc_ff <= `RRSO_PC_RST;
      sp_ff <= 3'h0;
      for (int i = 0; i < 8; i++)
        stack_ff[i] <= `RRSO_PC_RST;
    end
    else if (commit && (dec.kind == RRSO_K_RET))
    begin
      pc_ff <= stackTop;
      sp_ff <= sp_ff - 3'h1;
    end
    else if (commit)
    begin
      pc_ff <= pc_ff + 13'h0001;
    end
    else if (swIdleWr && busWrite(aph_ff, `RRSO_OFF_PC))
    begin
      pc_ff <= hwdata[12:0];
    end
    else if (swIdleWr && busWrite(aph_ff, `RRSO_OFF_STACK))
    begin
      stack_ff[sp_ff] <= hwdata[12:0];
      sp_ff <= sp_ff + 3'h1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      oscStop_ff <= 1'b0;
      wdtClear_ff <= 1'b0;
      prescClear_ff <= 1'b0;
    end
    else
    begin
      wdtClear_ff <= commit && (dec.kind == RRSO_K_SLEEP);
      prescClear_ff <= commit && (dec.kind == RRSO_K_SLEEP);
      if (commit && (dec.kind == RRSO_K_SLEEP))
        oscStop_ff <= 1'b1;
      else if ((state_ff == RRSO_SLEEP) && wakeSync_ff)
        oscStop_ff <= 1'b0;
    end
  end

  assign oscStop = oscStop_ff;
  assign wdtClear = wdtClear_ff;
  assign prescClear = prescClear_ff;
  assign discardFetch = (state_ff == RRSO_FLUSH);

  // The executing rotate owns the memory port; software writes reach it only while idle.
  always_comb
  begin
    memReq.we = swIdleWr && busWrite(aph_ff, `RRSO_OFF_FDATA);
    memReq.addr = fileAddr_ff;
    memReq.wdata = hwdata[7:0];
    if (state_ff == RRSO_EXEC)
    begin
      memReq.addr = dec.fAddr;
      memReq.we = commit && isRot && dec.dest;
      memReq.wdata = rotResult[7:0];
    end
  end

  rrso_file_mem u_file_mem
  (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .memReq(memReq),
    .rdData_ff(memRdata)
  );

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      fileAddr_ff <= 7'h00;
    else if (busWrite(aph_ff, `RRSO_OFF_FADDR))
      fileAddr_ff <= hwdata[6:0];
  end

  always_comb
  begin
    statusWord = 32'h0000_0000;
    statusWord[`RRSO_ST_CARRY] = carry_ff;
    statusWord[`RRSO_ST_PDOWN] = pdown_ff;
    statusWord[`RRSO_ST_TOUT] = tout_ff;
    statusWord[`RRSO_ST_BUSY] = (state_ff == RRSO_EXEC);
    statusWord[`RRSO_ST_ASLEEP] = (state_ff == RRSO_SLEEP);
    statusWord[`RRSO_ST_FLUSH] = (state_ff == RRSO_FLUSH);
  end

  always_comb
  begin
    readMux = 32'h0000_0000;
    case (haddr[11:0])
      `RRSO_OFF_INSTR: readMux[13:0] = instr_ff;
      `RRSO_OFF_STATUS: readMux = statusWord;
      `RRSO_OFF_WREG: readMux[7:0] = wreg_ff;
      `RRSO_OFF_PC: readMux[12:0] = pc_ff;
      `RRSO_OFF_STACK: readMux = {13'h0000, sp_ff, 3'h0, stackTop};
      `RRSO_OFF_FADDR: readMux[6:0] = fileAddr_ff;
      default: readMux = 32'h0000_0000;
    endcase
  end

  // Window reads wait two clocks so that a fresh address reaches the registered memory output.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      aph_ff <= '0;
      hrdata_ff <= 32'h0000_0000;
      fdWait_ff <= 2'h0;
    end
    else if (fdWait_ff != 2'h0)
    begin
      fdWait_ff <= fdWait_ff - 2'h1;
      if (fdWait_ff == 2'h1)
        hrdata_ff <= {24'h000000, memRdata};
    end
    else if (hready)
    begin
      aph_ff <= '{sel: hsel && htrans[1], wr: hwrite, addr: haddr[11:0]};
      if (hsel && htrans[1] && !hwrite)
      begin
        hrdata_ff <= readMux;
        if (haddr[11:0] == `RRSO_OFF_FDATA)
          fdWait_ff <= `RRSO_FD_WAIT;
      end
    end
  end

  assign hreadyout = (fdWait_ff == 2'h0);
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  a_ret_pc_load: assert property (commit && dec.kind == RRSO_K_RET |=>
    pc_ff == $past(stackTop) && sp_ff == $past(sp_ff) - 3'h1)
    else $error("Return did not load the stack top into the program counter.");

  a_ret_flush_len: assert property (commit && dec.kind == RRSO_K_RET |=>
    discardFetch [*4] ##1 !discardFetch)
    else $error("Return discard cycle has the wrong length.");

  a_ret_flags_keep: assert property (state_ff == RRSO_FLUSH |->
    $stable(carry_ff) && $stable(tout_ff) && $stable(pdown_ff))
    else $error("Return changed a status flag.");

  a_rotl_result: assert property (commit && dec.kind == RRSO_K_ROTL && !dec.dest |->
    !memReq.we ##1 carry_ff == $past(memRdata[7]) && wreg_ff == {$past(memRdata[6:0]), $past(carry_ff)})
    else $error("Rotate left gave a wrong result or carry.");

  a_rotl_dest: assert property (commit && dec.kind == RRSO_K_ROTL && dec.dest |->
    memReq.we && memReq.addr == dec.fAddr && memReq.wdata == {memRdata[6:0], carry_ff} ##1 $stable(wreg_ff))
    else $error("Rotate left to file did not write the file register.");

  a_rotr_result: assert property (commit && dec.kind == RRSO_K_ROTR |=>
    carry_ff == $past(memRdata[0]) && $stable(tout_ff) && $stable(pdown_ff))
    else $error("Rotate right gave a wrong carry or touched other flags.");

  a_rotr_dest: assert property (commit && dec.kind == RRSO_K_ROTR |->
    (dec.dest && memReq.we && memReq.wdata == {carry_ff, memRdata[7:1]}) or
    (!dec.dest && !memReq.we ##1 wreg_ff == {$past(carry_ff), $past(memRdata[7:1])}))
    else $error("Rotate right result went to the wrong destination.");

  a_sleep_flags: assert property (commit && dec.kind == RRSO_K_SLEEP |=>
    !pdown_ff && tout_ff && $stable(carry_ff))
    else $error("Sleep did not update the power flags.");

  a_sleep_wdt: assert property (commit && dec.kind == RRSO_K_SLEEP |=>
    wdtClear && prescClear ##1 !wdtClear && !prescClear)
    else $error("Sleep did not clear the watchdog once.");

  a_sleep_hold: assert property (state_ff == RRSO_SLEEP && !wakeSync_ff |=>
    state_ff == RRSO_SLEEP && oscStop)
    else $error("Core left sleep without a wake event.");

  a_rot_one_cycle: assert property (issue && (hwdata[13:8] inside {`RRSO_OP_ROTL, `RRSO_OP_ROTR}) |=>
    state_ff == RRSO_EXEC ##3 commit ##1 state_ff == RRSO_IDLE)
    else $error("Rotate did not finish in one instruction cycle.");

  c_return_done: cover property (commit && dec.kind == RRSO_K_RET ##5 state_ff == RRSO_IDLE);
  c_rot_to_file: cover property (commit && isRot && dec.dest);
  c_sleep_wake: cover property (state_ff == RRSO_SLEEP ##1 wakeSync_ff ##1 state_ff == RRSO_IDLE);

endmodule : rrso_core

// ---- common/rrso_map.svh ----
`ifndef RRSO_MAP_SVH
`define RRSO_MAP_SVH

// Register byte offsets on the bus.
`define RRSO_OFF_INSTR 12'h000
`define RRSO_OFF_STATUS 12'h004
`define RRSO_OFF_WREG 12'h008
`define RRSO_OFF_PC 12'h00c
`define RRSO_OFF_STACK 12'h010
`define RRSO_OFF_FADDR 12'h014
`define RRSO_OFF_FDATA 12'h018

// Status register bit positions.
`define RRSO_ST_CARRY 0
`define RRSO_ST_PDOWN 1
`define RRSO_ST_TOUT 2
`define RRSO_ST_BUSY 8
`define RRSO_ST_ASLEEP 9
`define RRSO_ST_FLUSH 10

// Stack register read layout.
`define RRSO_STK_PTR_LSB 16

// Instruction encodings.
`define RRSO_OP_RETURN 14'h0008
`define RRSO_OP_SLEEP 14'h0063
`define RRSO_OP_ROTL 6'h0d
`define RRSO_OP_ROTR 6'h0c

// One instruction cycle is four clocks; this is the index of its last clock.
`define RRSO_QLAST 2'h3
// Extra clocks a memory window read holds the bus.
`define RRSO_FD_WAIT 2'h2

// Reset values.
`define RRSO_PC_RST 13'h0000
`define RRSO_TOUT_RST 1'b1
`define RRSO_PDOWN_RST 1'b1
`define RRSO_CARRY_RST 1'b0
`define RRSO_WREG_RST 8'h00

`endif

// ---- common/rrso_pkg.sv ----
package rrso_pkg;

  typedef enum logic [2:0]
  {
    RRSO_K_NONE,
    RRSO_K_RET,
    RRSO_K_SLEEP,
    RRSO_K_ROTL,
    RRSO_K_ROTR
  } rrso_kind_t;

  typedef enum logic [1:0]
  {
    RRSO_IDLE,
    RRSO_EXEC,
    RRSO_FLUSH,
    RRSO_SLEEP
  } rrso_state_t;

  typedef struct packed
  {
    rrso_kind_t kind;
    logic dest;
    logic [6:0] fAddr;
  } rrso_dec_t;

  typedef struct packed
  {
    logic sel;
    logic wr;
    logic [11:0] addr;
  } rrso_aphase_t;

  typedef struct packed
  {
    logic we;
    logic [6:0] addr;
    logic [7:0] wdata;
  } rrso_memreq_t;

endpackage : rrso_pkg

// ---- rtl/rrso_file_mem.sv ----
module rrso_file_mem
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire rrso_pkg::rrso_memreq_t memReq,
  output logic [7:0] rdData_ff
);
  import rrso_pkg::*;

  logic [7:0] mem [128];

  // A write and a read of the same address return the old byte.
  always_ff @(posedge ref_clk)
  begin
    if (memReq.we)
    begin
      mem[memReq.addr] <= memReq.wdata;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      rdData_ff <= 8'h00;
    end
    else
    begin
      rdData_ff <= mem[memReq.addr];
    end
  end

endmodule : rrso_file_mem

// ---- tb/rrso_core_tb.sv ----
`include "rrso_map.svh"

module rrso_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import rrso_pkg::*;

  logic ref_clk;
  logic rst_b;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic wakeEvent;
  logic oscStop;
  logic wdtClear;
  logic prescClear;
  logic discardFetch;
  logic [31:0] rdVal;
  int miscompares;
  int numChecks;
  int dfCount;
  int clrCount;
  int bothCount;

  // The single slave drives the bus ready, so the data phase stretches with it.
  assign hready = hreadyout;

  rrso_core DUT
  (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .wakeEvent(wakeEvent),
    .oscStop(oscStop),
    .wdtClear(wdtClear),
    .prescClear(prescClear),
    .discardFetch(discardFetch)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Counters are cleared only while the pulses are idle, so the edge race cannot lose a count.
  always @(posedge ref_clk)
  begin
    if (discardFetch === 1'b1) dfCount++;
    if (wdtClear === 1'b1 || prescClear === 1'b1) clrCount++;
    if (wdtClear === 1'b1 && prescClear === 1'b1) bothCount++;
  end

  task complete_run;
    $display("checks %0d, miscompares %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  task check(input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: expected %h, got %h", $time, exp, got);
    end
  endtask : check

  task check_count(input int exp, input int got);
    numChecks++;
    if (got != exp)
    begin
      miscompares++;
      $display("wrong value at %0t: expected %h, got %h", $time, exp, got);
    end
  endtask : check_count

  task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rdVal);
  endtask : wr

  task rd(input logic [11:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h00000000, d);
  endtask : rd

  task wait_idle;
    logic [31:0] s;
    for (int n = 0; n < 40; n++)
    begin
      rd(`RRSO_OFF_STATUS, s);
      if (s[`RRSO_ST_BUSY] === 1'b0 && s[`RRSO_ST_FLUSH] === 1'b0) break;
    end
  endtask : wait_idle

  task t_reset;
    logic [31:0] s;
    rd(`RRSO_OFF_STATUS, s);
    check(32'h00000006, s);
    rd(`RRSO_OFF_WREG, s);
    check(32'h00000000, s);
    rd(`RRSO_OFF_PC, s);
    check(32'h00000000, s);
    rd(12'h01c, s);
    check(32'h00000000, s);
    check({31'h0, hresp}, 32'h00000000);
    check(32'h00000001, {31'h0, hreadyout});
    check({31'h0, oscStop}, 32'h00000000);
  endtask : t_reset

  task t_rotate(input logic [5:0] op, input logic d, input logic [6:0] f, input logic [7:0] v, input logic c);
    logic [7:0] res;
    logic co;
    logic [31:0] w0;
    logic [31:0] pc0;
    logic [31:0] s;
    wr(`RRSO_OFF_FADDR, {25'h0, f});
    wr(`RRSO_OFF_FDATA, {24'h0, v});
    wr(`RRSO_OFF_STATUS, {31'h0, c});
    rd(`RRSO_OFF_WREG, w0);
    rd(`RRSO_OFF_PC, pc0);
    res = (op == `RRSO_OP_ROTL) ? {v[6:0], c} : {c, v[7:1]};
    co = (op == `RRSO_OP_ROTL) ? v[7] : v[0];
    wr(`RRSO_OFF_INSTR, {18'h0, op, d, f});
    wait_idle();
    rd(`RRSO_OFF_WREG, s);
    check(d ? w0 : {24'h0, res}, s);
    rd(`RRSO_OFF_FDATA, s);
    check(d ? {24'h0, res} : {24'h0, v}, s);
    rd(`RRSO_OFF_STATUS, s);
    check({31'h3, co} & 32'h00000007 | 32'h00000006, s);
    rd(`RRSO_OFF_PC, s);
    check(pc0 + 32'h1, s);
  endtask : t_rotate

  task t_return;
    logic [31:0] s;
    wr(`RRSO_OFF_STACK, 32'h00000abc);
    wr(`RRSO_OFF_STATUS, 32'h00000001);
    dfCount = 0;
    wr(`RRSO_OFF_INSTR, {18'h0, `RRSO_OP_RETURN});
    wait_idle();
    rd(`RRSO_OFF_PC, s);
    check(32'h00000abc, s);
    rd(`RRSO_OFF_STACK, s);
    check(32'h00000000, {29'h0, s[18:16]});
    check_count(4, dfCount);
    rd(`RRSO_OFF_STATUS, s);
    check(32'h00000007, s);
  endtask : t_return

  task t_sleep;
    logic [31:0] s;
    logic [31:0] w0;
    logic [31:0] pc0;
    wr(`RRSO_OFF_STATUS, 32'h00000001);
    rd(`RRSO_OFF_WREG, w0);
    rd(`RRSO_OFF_PC, pc0);
    clrCount = 0;
    bothCount = 0;
    wr(`RRSO_OFF_INSTR, {18'h0, `RRSO_OP_SLEEP});
    for (int n = 0; n < 20 && oscStop !== 1'b1; n++) @(posedge ref_clk);
    // One more edge lets the pulse counters finish the edge at which the loop woke.
    @(posedge ref_clk);
    check({31'h0, oscStop}, 32'h00000001);
    check_count(1, clrCount);
    check_count(1, bothCount);
    rd(`RRSO_OFF_STATUS, s);
    check(32'h00000205, s);
    wr(`RRSO_OFF_INSTR, {18'h0, `RRSO_OP_ROTL, 1'b0, 7'h05});
    repeat (8) @(posedge ref_clk);
    rd(`RRSO_OFF_PC, s);
    check(pc0 + 32'h1, s);
    wakeEvent <= 1'b1;
    for (int n = 0; n < 20 && oscStop !== 1'b0; n++) @(posedge ref_clk);
    wakeEvent <= 1'b0;
    check({31'h0, oscStop}, 32'h00000000);
    rd(`RRSO_OFF_WREG, s);
    check(w0, s);
    rd(`RRSO_OFF_STATUS, s);
    check(32'h00000005, s);
  endtask : t_sleep

  initial
  begin
    miscompares = 0;
    numChecks = 0;
    dfCount = 0;
    clrCount = 0;
    bothCount = 0;
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    wakeEvent = 1'b0;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_rotate(`RRSO_OP_ROTL, 1'b0, 7'h05, 8'he6, 1'b0);
    t_rotate(`RRSO_OP_ROTL, 1'b1, 7'h7f, 8'h55, 1'b1);
    t_rotate(`RRSO_OP_ROTR, 1'b0, 7'h00, 8'h01, 1'b1);
    t_rotate(`RRSO_OP_ROTR, 1'b1, 7'h40, 8'h02, 1'b1);
    t_return();
    t_sleep();
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    complete_run();
  end

  // The whole sequence needs a few hundred clocks; this span of 25000 clocks leaves ample margin.
  initial
  begin
    #200000;
    miscompares++;
    $display("watchdog span ran out at %0t", $time);
    complete_run();
  end

endmodule : rrso_core_tb
